// [rtl/mpsc_map.svh]
// Purpose: offsets, field positions, reset values and counts
// Assumes: register index = wishbone byte address / 4
// Notes:   same index is used by the serial frame address field
`ifndef MPSC_MAP_SVH
`define MPSC_MAP_SVH

// register indices
`define MPSC_IDX_CTRL      5'h00
`define MPSC_IDX_GPO       5'h01
`define MPSC_IDX_MIX       5'h02
`define MPSC_IDX_STAT      5'h03
`define MPSC_IDX_PLL1      5'h04
`define MPSC_IDX_PLL2      5'h05

// serial interface control register fields
`define MPSC_CB_SOFT       0
`define MPSC_CB_FOUR       1
`define MPSC_CB_SLICE      2
`define MPSC_CB_MODE       3
`define MPSC_CB_ENABLE     4
`define MPSC_CB_RESET      5
`define MPSC_CB_RELOCK     6
`define MPSC_CB_DUAL       7
`define MPSC_CB_PINGPO     8
`define MPSC_CTRL_W        9
`define MPSC_CTRL_RST      9'h000

// general outputs: path 1 low byte, path 2 high byte
`define MPSC_GPO_RST       16'h0000
`define MPSC_MIX_RST       3'h4

// serial frame layout: rw, slice id, address, data
`define MPSC_SER_HDR_BITS  5'h08
`define MPSC_SER_FRM_BITS  5'h18

// calibration phase lengths in clock cycles
`define MPSC_VCO_SEL_CYC   16'h0040
`define MPSC_BAND_CYC      16'h0100

`endif

// [rtl/mpsc_pkg.sv]
// Purpose: shared types of the mixer path and serial control block
// Assumes: constants come from mpsc_map.svh
// Notes:   none
package mpsc_pkg;

  // write request from either register port
  typedef struct packed {
    logic [4:0]  idx;
    logic [15:0] data;
    logic [1:0]  be;
  } mpsc_wr_t;

  // routing outputs towards the analog section
  typedef struct packed {
    logic bank2;
    logic mixer1;
    logic mixer2;
  } mpsc_route_t;

  // calibration sequencer states
  typedef enum logic [2:0] {
    CAL_IDLE    = 3'b000,
    CAL_VCO_SEL = 3'b001,
    CAL_BAND    = 3'b010,
    CAL_LOCKING = 3'b011,
    CAL_LOCKED  = 3'b100
  } mpsc_cal_state_t;

endpackage

// [rtl/mpsc_serial_slave.sv]
// Purpose: 3/4-line serial slave with multi-slice addressing
// Assumes: serial pins are synchronous to clk_i, sclk well below clk_i
// Notes:   frame is rw, id[1:0], addr[4:0], data[15:0], msb first
`timescale 1ns/1ps
`default_nettype none
`include "mpsc_map.svh"

module mpsc_serial_slave
  import mpsc_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        clear_i,
  // serial pins
  input  wire logic        sclk_i,
  input  wire logic        sen_n_i,
  input  wire logic        sdata_i,
  output logic             sdata_o,
  output logic             sdata_oe_n_o,
  output logic             sdo_o,
  // configuration
  input  wire logic        four_line_i,
  input  wire logic        slice_en_i,
  input  wire logic [1:0]  slice_id_i,
  // register side
  input  wire logic [15:0] rdata_i,
  output logic [4:0]       rd_idx_o,
  output mpsc_wr_t         wr_o,
  output logic             wr_vld_o
);

  logic        sclk_q;
  logic [4:0]  cnt_q;
  logic [22:0] sh_q;
  logic        rd_q;
  logic        match_q;
  logic        hdr_done_q;
  logic [15:0] out_q;
  logic        drv3_q;
  logic        drv4_q;
  logic        rise;
  logic        fall;
  logic [7:0]  hdr;

  assign rise = sclk_i & ~sclk_q;
  assign fall = ~sclk_i & sclk_q;
  assign hdr  = {sh_q[6:0], sdata_i};

  ////////////////////////////////////////////////////////////////////////
  // input shifting and header decode
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sclk_q     <= 1'b0;
      cnt_q      <= 5'h00;
      sh_q       <= 23'h000000;
      rd_q       <= 1'b0;
      match_q    <= 1'b0;
      hdr_done_q <= 1'b0;
      rd_idx_o   <= 5'h00;
      wr_vld_o   <= 1'b0;
      wr_o       <= '0;
    end else begin
      sclk_q     <= sclk_i;
      hdr_done_q <= 1'b0;
      wr_vld_o   <= 1'b0;
      if (clear_i || sen_n_i) begin
        cnt_q <= 5'h00;
      end else if (rise && cnt_q != `MPSC_SER_FRM_BITS) begin
        sh_q  <= {sh_q[21:0], sdata_i};
        cnt_q <= cnt_q + 5'h01;
        if (cnt_q == `MPSC_SER_HDR_BITS - 5'h01) begin
          rd_q       <= hdr[7];
          rd_idx_o   <= hdr[4:0];
          hdr_done_q <= 1'b1;
          // before slice select is on, every device takes the frame
          match_q    <= ~slice_en_i | (hdr[6:5] == slice_id_i);
        end
        if (cnt_q == `MPSC_SER_FRM_BITS - 5'h01 && !rd_q && match_q) begin
          wr_vld_o   <= 1'b1;
          wr_o.idx   <= rd_idx_o;
          wr_o.data  <= {sh_q[14:0], sdata_i};
          wr_o.be    <= 2'h3;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data shifted out after the header, on falling edges
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      out_q  <= 16'h0000;
      drv3_q <= 1'b0;
      drv4_q <= 1'b0;
    end else if (clear_i || sen_n_i) begin
      drv3_q <= 1'b0;
      drv4_q <= 1'b0;
    end else if (hdr_done_q) begin
      out_q  <= rdata_i;
      drv3_q <= rd_q & match_q & ~four_line_i;
      drv4_q <= rd_q & match_q & four_line_i;
    end else if (fall && cnt_q > `MPSC_SER_HDR_BITS) begin
      out_q  <= {out_q[14:0], 1'b0};
    end
  end

  // shared data pin in 3-line mode, separate output in 4-line mode
  assign sdata_o      = out_q[15];
  assign sdata_oe_n_o = ~drv3_q;
  assign sdo_o        = out_q[15] & drv4_q;

endmodule
`default_nettype wire

// [rtl/mpsc_cal_seq.sv]
// Purpose: vco select, coarse band tuning and lock sequencer
// Assumes: lock_i is the analog lock window flag, synchronous
// Notes:   a trigger while disabled is dropped
`timescale 1ns/1ps
`default_nettype none
`include "mpsc_map.svh"

module mpsc_cal_seq
  import mpsc_pkg::*;
#(
  parameter logic [15:0] SEL_CYC  = `MPSC_VCO_SEL_CYC,
  parameter logic [15:0] BAND_CYC = `MPSC_BAND_CYC
) (
  // clock and reset
  input  wire logic      clk_i,
  input  wire logic      reset_i,
  input  wire logic      clear_i,
  // control
  input  wire logic      enable_i,
  input  wire logic      trigger_i,
  input  wire logic      lock_i,
  // status
  output mpsc_cal_state_t state_o,
  output logic           busy_o,
  output logic           locked_o
);

  mpsc_cal_state_t state_q;
  logic [15:0]     cnt_q;

  ////////////////////////////////////////////////////////////////////////
  // sequence: select vco, tune band, wait for lock
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= CAL_IDLE;
      cnt_q   <= 16'h0000;
    end else if (clear_i || !enable_i) begin
      state_q <= CAL_IDLE;
      cnt_q   <= 16'h0000;
    end else if (trigger_i) begin
      state_q <= CAL_VCO_SEL;
      cnt_q   <= 16'h0000;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
      case (state_q)
        CAL_VCO_SEL: begin
          if (cnt_q == SEL_CYC - 16'h0001) begin
            state_q <= CAL_BAND;
            cnt_q   <= 16'h0000;
          end
        end
        CAL_BAND: begin
          if (cnt_q == BAND_CYC - 16'h0001) begin
            state_q <= CAL_LOCKING;
            cnt_q   <= 16'h0000;
          end
        end
        CAL_LOCKING: begin
          cnt_q <= 16'h0000;
          if (lock_i) begin
            state_q <= CAL_LOCKED;
          end
        end
        CAL_LOCKED: begin
          cnt_q <= 16'h0000;
        end
        default: begin
          cnt_q <= 16'h0000;
        end
      endcase
    end
  end

  assign state_o  = state_q;
  assign busy_o   = (state_q == CAL_VCO_SEL) || (state_q == CAL_BAND);
  assign locked_o = (state_q == CAL_LOCKED) & lock_i;

endmodule
`default_nettype wire

// [rtl/mpsc_top.sv]
// Purpose: mixer path selection, hardware/software control, registers
// Assumes: pins synchronous to clk_i; reset_i is the power-on reset
// Notes:   registers reachable over wishbone and the serial bus
//
// Behaviour
// - with dual mixer select clear, mode low uses bank 1 and mixer 1, high uses bank 2 and mixer 2.
// - with dual mixer select set, both mixers get the LO and mode still picks the bank.
// - the serial bus does writes and reads and reaches every register.
// - with four line select set, read data leaves on its own output pin.
// - the analog enable powers the analog side and its rise starts vco select, band tuning and then locking.
// - power-on reset returns all logic to its startup state; the low hardware reset pin clears the registers, calibration and serial frame.
// - with soft control select set, mode, enable and reset come from the control register, pins ignored.
// - under soft control the two hardware control pins may serve as general outputs.
// - up to four devices share one serial bus, each identified by two slice pins.
// - after power-up or reset the slice pins are ignored and every serial write is taken.
// - once slice select enable is set the device adopts the identity on its slice pins.
// - general outputs hold a set per mixer path and mode picks which set drives the pins.
// - mixer current setting is programmable with default code 100.
// - the self-clearing re-lock bit restarts calibration like an enable rise.
//
// Local design decisions: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "mpsc_map.svh"

module mpsc_top
  import mpsc_pkg::*;
#(
  parameter int          GPO_W    = 6,
  parameter logic [15:0] SEL_CYC  = `MPSC_VCO_SEL_CYC,
  parameter logic [15:0] BAND_CYC = `MPSC_BAND_CYC
) (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              reset_i,
  // wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic [31:0]            wb_dat_o,
  output logic                   wb_ack_o,
  // hardware control pins
  input  wire logic              analog_enable_pin_i,
  input  wire logic              mode_pin_i,
  input  wire logic              hw_reset_n_pin_i,
  // control pins reused as general outputs
  output logic [1:0]             aux_gpo_o,
  output logic [1:0]             aux_gpo_oe_n_o,
  // serial bus
  input  wire logic              sclk_i,
  input  wire logic              sen_n_i,
  input  wire logic              sdata_i,
  output logic                   sdata_o,
  output logic                   sdata_oe_n_o,
  output logic                   sdo_o,
  input  wire logic              slice_id_pin_a_i,
  input  wire logic              slice_id_pin_b_i,
  // analog side
  input  wire logic              pll_lock_i,
  output logic                   analog_en_o,
  output mpsc_route_t            route_o,
  output logic [2:0]             mixer_current_o,
  output logic [15:0]            pll1_word_o,
  output logic [15:0]            pll2_word_o,
  output logic [GPO_W-1:0]       general_outputs_o
);

  // control register and its named bits
  logic [`MPSC_CTRL_W-1:0] ctrl_q;
  logic [`MPSC_CTRL_W-1:0] ctrl_d;
  logic [15:0]             ctrl_m;
  logic [15:0]             gpo_q;
  logic [2:0]              mix_q;
  logic [15:0]             pll1_q;
  logic [15:0]             pll2_q;
  logic [1:0]              slice_id_q;
  logic                    soft_rst_q;
  logic                    en_prev_q;
  logic                    wb_ack_q;
  logic [31:0]             wb_dat_q;

  logic                    soft_control_select;
  logic                    four_line_select;
  logic                    dual_mixer_select;
  logic                    slice_en;
  logic                    eff_mode;
  logic                    eff_en;
  logic                    dig_rst;
  logic                    relock_pulse;
  logic                    en_rise;

  // shared write port
  mpsc_wr_t                ser_wr;
  logic                    ser_wr_vld;
  logic                    wb_req;
  logic                    wb_wr;
  mpsc_wr_t                wr;
  logic                    wr_vld;
  logic [4:0]              ser_rd_idx;
  logic [15:0]             ser_rdata;
  logic [15:0]             wb_rdata;

  // calibration status
  mpsc_cal_state_t         cal_state;
  logic                    cal_busy;
  logic                    cal_locked;

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // merge write data into a 16-bit register by byte lane
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [15:0] nw,
                                          input logic [1:0]  be);
    merge16 = old;
    if (be[0]) begin
      merge16[7:0] = nw[7:0];
    end
    if (be[1]) begin
      merge16[15:8] = nw[15:8];
    end
  endfunction

  // true when the shared write port hits a given register
  function automatic logic hit(input logic     vld,
                               input mpsc_wr_t w,
                               input logic [4:0] idx);
    hit = vld && (w.idx == idx);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // effective control: pins or control register

  assign soft_control_select = ctrl_q[`MPSC_CB_SOFT];
  assign four_line_select    = ctrl_q[`MPSC_CB_FOUR];
  assign dual_mixer_select   = ctrl_q[`MPSC_CB_DUAL];
  assign slice_en            = ctrl_q[`MPSC_CB_SLICE];

  assign eff_mode = soft_control_select ? ctrl_q[`MPSC_CB_MODE]
                                        : mode_pin_i;
  assign eff_en   = soft_control_select ? ctrl_q[`MPSC_CB_ENABLE]
                                        : analog_enable_pin_i;
  // digital reset from the pin or from the soft reset bit
  assign dig_rst  = soft_control_select ? soft_rst_q
                                        : ~hw_reset_n_pin_i;

  ////////////////////////////////////////////////////////////////////////
  // register port arbitration: serial writes take precedence

  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_q;
  assign wb_wr  = wb_req & wb_we_i & ~ser_wr_vld;

  always_comb begin
    if (ser_wr_vld) begin
      wr = ser_wr;
    end else begin
      wr.idx  = wb_adr_i[6:2];
      wr.data = wb_dat_i[15:0];
      wr.be   = wb_sel_i[1:0];
    end
  end
  assign wr_vld = ser_wr_vld | (wb_wr & (wb_adr_i[7] == 1'b0));

  ////////////////////////////////////////////////////////////////////////
  // control register next value; re-lock and soft reset self-clear

  assign ctrl_m = merge16({{(16-`MPSC_CTRL_W){1'b0}}, ctrl_q}, wr.data,
                          wr.be);

  always_comb begin
    ctrl_d = ctrl_q;
    if (hit(wr_vld, wr, `MPSC_IDX_CTRL)) begin
      ctrl_d = ctrl_m[`MPSC_CTRL_W-1:0];
    end
    ctrl_d[`MPSC_CB_RELOCK] = 1'b0;
    ctrl_d[`MPSC_CB_RESET]  = 1'b0;
  end

  assign relock_pulse = hit(wr_vld, wr, `MPSC_IDX_CTRL) & wr.be[0] &
                        wr.data[`MPSC_CB_RELOCK];

  // control register
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_q <= `MPSC_CTRL_RST;
    end else if (dig_rst) begin
      ctrl_q <= `MPSC_CTRL_RST;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // soft reset request: one-cycle pulse from the control register
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= hit(wr_vld, wr, `MPSC_IDX_CTRL) & wr.be[0] &
                    wr.data[`MPSC_CB_RESET] & wr.data[`MPSC_CB_SOFT];
    end
  end

  // slice identity caught when slice select turns on
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      slice_id_q <= 2'h0;
    end else if (dig_rst) begin
      slice_id_q <= 2'h0;
    end else if (!slice_en && ctrl_d[`MPSC_CB_SLICE]) begin
      slice_id_q <= {slice_id_pin_b_i, slice_id_pin_a_i};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // data registers: general outputs, mixer current, pll words

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      gpo_q  <= `MPSC_GPO_RST;
      mix_q  <= `MPSC_MIX_RST;
      pll1_q <= 16'h0000;
      pll2_q <= 16'h0000;
    end else if (dig_rst) begin
      gpo_q  <= `MPSC_GPO_RST;
      mix_q  <= `MPSC_MIX_RST;
      pll1_q <= 16'h0000;
      pll2_q <= 16'h0000;
    end else begin
      if (hit(wr_vld, wr, `MPSC_IDX_GPO)) begin
        gpo_q <= merge16(gpo_q, wr.data, wr.be);
      end
      if (hit(wr_vld, wr, `MPSC_IDX_MIX) && wr.be[0]) begin
        mix_q <= wr.data[2:0];
      end
      if (hit(wr_vld, wr, `MPSC_IDX_PLL1)) begin
        pll1_q <= merge16(pll1_q, wr.data, wr.be);
      end
      if (hit(wr_vld, wr, `MPSC_IDX_PLL2)) begin
        pll2_q <= merge16(pll2_q, wr.data, wr.be);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux shared by both register ports

  function automatic logic [15:0] rd_mux(input logic [4:0] idx);
    case (idx)
      `MPSC_IDX_CTRL: rd_mux = {{(16-`MPSC_CTRL_W){1'b0}}, ctrl_q};
      `MPSC_IDX_GPO:  rd_mux = gpo_q;
      `MPSC_IDX_MIX:  rd_mux = {13'h0000, mix_q};
      `MPSC_IDX_STAT: rd_mux = {3'h0, cal_state, cal_locked, cal_busy,
                                route_o.mixer2, route_o.mixer1,
                                route_o.bank2, analog_en_o, eff_mode,
                                slice_en, slice_id_q};
      `MPSC_IDX_PLL1: rd_mux = pll1_q;
      `MPSC_IDX_PLL2: rd_mux = pll2_q;
      default:        rd_mux = 16'h0000;
    endcase
  endfunction

  // process form so register changes inside rd_mux are seen
  always_comb begin
    ser_rdata = rd_mux(ser_rd_idx);
    wb_rdata  = wb_adr_i[7] ? 16'h0000 : rd_mux(wb_adr_i[6:2]);
  end

  ////////////////////////////////////////////////////////////////////////
  // wishbone answer: ack one cycle after the request, a write held off by
  // a serial write in the same cycle

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      wb_ack_q <= 1'b0;
      wb_dat_q <= 32'h00000000;
    end else begin
      wb_ack_q <= wb_req & ~(wb_we_i & ser_wr_vld);
      if (wb_req && !wb_we_i) begin
        wb_dat_q <= {16'h0000, wb_rdata};
      end
    end
  end

  assign wb_ack_o = wb_ack_q;
  assign wb_dat_o = wb_dat_q;

  ////////////////////////////////////////////////////////////////////////
  // enable rise detection and calibration sequencer

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      en_prev_q <= 1'b0;
    end else begin
      en_prev_q <= eff_en;
    end
  end

  assign en_rise = eff_en & ~en_prev_q;

  mpsc_cal_seq #(
    .SEL_CYC  (SEL_CYC),
    .BAND_CYC (BAND_CYC)
  ) u_cal (
    .clk_i     (clk_i),
    .reset_i   (reset_i),
    .clear_i   (dig_rst),
    .enable_i  (eff_en),
    .trigger_i (en_rise | relock_pulse),
    .lock_i    (pll_lock_i),
    .state_o   (cal_state),
    .busy_o    (cal_busy),
    .locked_o  (cal_locked)
  );

  ////////////////////////////////////////////////////////////////////////
  // serial slave

  mpsc_serial_slave u_ser (
    .clk_i        (clk_i),
    .reset_i      (reset_i),
    .clear_i      (dig_rst),
    .sclk_i       (sclk_i),
    .sen_n_i      (sen_n_i),
    .sdata_i      (sdata_i),
    .sdata_o      (sdata_o),
    .sdata_oe_n_o (sdata_oe_n_o),
    .sdo_o        (sdo_o),
    .four_line_i  (four_line_select),
    .slice_en_i   (slice_en),
    .slice_id_i   (slice_id_q),
    .rdata_i      (ser_rdata),
    .rd_idx_o     (ser_rd_idx),
    .wr_o         (ser_wr),
    .wr_vld_o     (ser_wr_vld)
  );

  ////////////////////////////////////////////////////////////////////////
  // registered outputs to the analog side and pins

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      analog_en_o       <= 1'b0;
      route_o           <= '0;
      mixer_current_o   <= `MPSC_MIX_RST;
      pll1_word_o       <= 16'h0000;
      pll2_word_o       <= 16'h0000;
      general_outputs_o <= '0;
      aux_gpo_o         <= 2'h0;
      aux_gpo_oe_n_o    <= 2'h3;
    end else begin
      analog_en_o     <= eff_en;
      route_o.bank2   <= eff_mode;
      route_o.mixer1  <= dual_mixer_select | ~eff_mode;
      route_o.mixer2  <= dual_mixer_select | eff_mode;
      mixer_current_o <= mix_q;
      pll1_word_o     <= pll1_q;
      pll2_word_o     <= pll2_q;
      // mode picks the path 1 or path 2 set
      general_outputs_o <= eff_mode ? gpo_q[8 +: GPO_W]
                                    : gpo_q[0 +: GPO_W];
      aux_gpo_o <= eff_mode ? gpo_q[15:14] : gpo_q[7:6];
      aux_gpo_oe_n_o <= {2{~(soft_control_select &
                             ctrl_q[`MPSC_CB_PINGPO])}};
    end
  end

endmodule
`default_nettype wire

// [testbench/mpsc_chk.sv]
// Purpose: port checks
// Assumes: bound to mpsc_top
// Notes: one clock
`timescale 1ns/1ps
`default_nettype none
module mpsc_chk
  import mpsc_pkg::*;
(
  // watched ports
  input wire logic        clk_i, reset_i, wb_cyc_i, wb_stb_i, wb_ack_o,
  input wire logic        sen_n_i, sdata_oe_n_o, sdo_o, analog_en_o,
  input wire logic [1:0]  aux_gpo_oe_n_o,
  input wire logic [2:0]  mixer_current_o,
  input wire mpsc_route_t route_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  ////////////////////////////////////////////////////////////////
  // bus answer
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("long ack");
  ack_cause_a: assert property (
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
  ack_due_a: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |-> ##[1:2] wb_ack_o)
    else $error("no ack");
  // mixer routing
  route_one_a: assert property (
    !$past(reset_i) |-> route_o.mixer1 || route_o.mixer2)
    else $error("no mixer");
  route_bank_a: assert property (
    !$past(reset_i) && !(route_o.mixer1 && route_o.mixer2) |->
    route_o.mixer2 == route_o.bank2) else $error("bank mismatch");
  // reset state, idle serial drivers
  rst_vals_a: assert property (
    $fell(reset_i) |-> aux_gpo_oe_n_o == 2'h3 && !analog_en_o)
    else $error("reset state");
  mix_rst_a: assert property (
    $fell(reset_i) |-> mixer_current_o == 3'h4) else $error("mixer code");
  ser_idle_a: assert property (
    sen_n_i [*3] |-> sdata_oe_n_o && !sdo_o) else $error("serial drive");
endmodule
`default_nettype wire

// [testbench/mpsc_host.sv]
// Purpose: serial host model
// Assumes: read back on sdo_o or on the shared line
// Notes: sclk rests low between frames
`timescale 1ns/1ps
`default_nettype none
module mpsc_host (
  // clock and serial pins
  input  wire logic clk_i, sdata_o, sdata_oe_n_o, sdo_o,
  output logic      sclk_o, sen_n_o, line_o
);
  logic drv_q = 1'b0;
  initial sclk_o = 1'b0;
  initial sen_n_o = 1'b1;
  // wire level, design wins while it drives
  assign line_o = sdata_oe_n_o ? drv_q : sdata_o;
  // one 24 bit frame msb first, half period 4 clocks
  task automatic xfer(input logic [23:0] f, output logic [15:0] q);
    q = 16'h0000;
    sen_n_o <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      drv_q <= f[i];
      repeat (4) @(posedge clk_i);
      sclk_o <= 1'b1;
      repeat (3) @(posedge clk_i);
      if (i < 16) q = {q[14:0], sdata_oe_n_o ? sdo_o : sdata_o};
      @(posedge clk_i);
      sclk_o <= 1'b0;
    end
    repeat (4) @(posedge clk_i);
    sen_n_o <= 1'b1;
    drv_q <= ~drv_q; // released line shows no stale level
    repeat (4) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// [testbench/mpsc_top_tb_top.sv]
// Purpose: self-checking bench of mpsc_top
// Assumes: short calibration counts
// Notes: slice pins give id 1
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("BAD t=%0t %h %h", $time, a, b); end end
module mpsc_top_tb_top;
  logic        clk_i, reset_i, cyc, we, mode, ena, hwr_n, lock, ack;
  logic        sclk, sen_n, sd_line, sd_o, sd_oe_n, sdo, aen;
  logic [1:0]  aux_oe_n, aux;
  logic [2:0]  route, mixc;
  logic [5:0]  general_outputs;
  logic [7:0]  adr;
  logic [15:0] p1, p2, sq;
  logic [31:0] dat, rd, rq;
  logic [4:0]  rows [4] = '{5'h02, 5'h15, 5'h0B, 5'h1F}; // mode,dual,route
  int          fail_count, n_checks;
  mpsc_top #(.SEL_CYC(16'h0004), .BAND_CYC(16'h0008)) mpsc_top_inst (
    .clk_i, .reset_i, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rd),
    .wb_ack_o(ack), .analog_enable_pin_i(ena), .mode_pin_i(mode),
    .hw_reset_n_pin_i(hwr_n), .aux_gpo_o(aux), .aux_gpo_oe_n_o(aux_oe_n),
    .sclk_i(sclk), .sen_n_i(sen_n), .sdata_i(sd_line), .sdata_o(sd_o),
    .sdata_oe_n_o(sd_oe_n), .sdo_o(sdo), .slice_id_pin_a_i(1'b1),
    .slice_id_pin_b_i(1'b0), .pll_lock_i(lock), .analog_en_o(aen),
    .route_o(route), .mixer_current_o(mixc), .pll1_word_o(p1),
    .pll2_word_o(p2), .general_outputs_o(general_outputs));
  mpsc_host mpsc_host_inst (.clk_i, .sdata_o(sd_o), .sdata_oe_n_o(sd_oe_n),
    .sdo_o(sdo), .sclk_o(sclk), .sen_n_o(sen_n), .line_o(sd_line));
  // 100 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // one classic cycle, held until ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do @(posedge clk_i); while (ack !== 1'b1 && ++n < 50);
    if (n >= 50) fail_count++;
    rq = rd;
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // main sequence
  initial begin
    {cyc, we, mode, ena, lock, adr, dat} = '0;
    hwr_n = 1'b1;
    reset_i = 1'b1;
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, 8'h08, 32'h0);
    `CHK(rq, 32'h4)
    wb(1'b1, 8'h04, 32'h9E63);
    foreach (rows[i]) begin
      mode <= rows[i][4];
      wb(1'b1, 8'h00, {24'h0, rows[i][3], 7'h00});
      repeat (2) @(posedge clk_i);
      `CHK(route, rows[i][2:0])
      `CHK(general_outputs, rows[i][4] ? 6'h1E : 6'h23)
    end
    wb(1'b0, 8'h80, 32'h0);
    `CHK(rq, 32'h0)
    wb(1'b1, 8'h08, 32'h1);
    `CHK(mixc, 3'h1)
    $display("registers done");
    mpsc_host_inst.xfer({1'b0, 2'h3, 5'h04, 16'h1234}, sq);
    `CHK(p1, 16'h1234)
    wb(1'b1, 8'h00, 32'h2);
    mpsc_host_inst.xfer({1'b1, 2'h0, 5'h04, 16'h0000}, sq);
    `CHK(sq, 16'h1234)
    wb(1'b1, 8'h00, 32'h6);
    mpsc_host_inst.xfer({1'b0, 2'h0, 5'h05, 16'hAAAA}, sq);
    `CHK(p2, 16'h0000)
    mpsc_host_inst.xfer({1'b0, 2'h1, 5'h05, 16'h5555}, sq);
    `CHK(p2, 16'h5555)
    wb(1'b1, 8'h00, 32'h4);
    mpsc_host_inst.xfer({1'b1, 2'h1, 5'h05, 16'h0000}, sq);
    `CHK(sq, 16'h5555)
    $display("serial done");
    ena <= 1'b1;
    repeat (30) @(posedge clk_i);
    wb(1'b0, 8'h0C, 32'h0);
    `CHK({aen, rq[12:10]}, 4'hB)
    lock <= 1'b1;
    @(posedge clk_i);
    wb(1'b0, 8'h0C, 32'h0);
    `CHK(rq[12:9], 4'h9)
    lock <= 1'b0; // drift drops the lock flag
    @(posedge clk_i);
    wb(1'b0, 8'h0C, 32'h0);
    `CHK(rq[12:9], 4'h8)
    wb(1'b1, 8'h00, 32'h46);
    wb(1'b0, 8'h0C, 32'h0);
    `CHK(rq[12:10] == 3'h4, 1'b0)
    wb(1'b0, 8'h00, 32'h0);
    `CHK(rq[6], 1'b0)
    $display("calibration done");
    hwr_n <= 1'b0;
    repeat (2) @(posedge clk_i);
    hwr_n <= 1'b1;
    repeat (3) @(posedge clk_i);
    `CHK({p1, mixc}, 19'h4)
    mode <= 1'b0;
    wb(1'b1, 8'h00, 32'h109);
    wb(1'b1, 8'h04, 32'h4000);
    repeat (2) @(posedge clk_i);
    `CHK({route[2], aen, aux_oe_n, aux}, 6'h21)
    wb(1'b1, 8'h08, 32'h2);
    wb(1'b1, 8'h00, 32'h21);
    repeat (2) @(posedge clk_i);
    `CHK(mixc, 3'h4)
    $display("control done");
    close_out();
  end
  // watchdog
  initial begin
    repeat (6000) @(posedge clk_i);
    fail_count++;
    close_out();
  end
endmodule
bind mpsc_top mpsc_chk mpsc_chk_inst (.clk_i, .reset_i, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o, .sen_n_i, .sdata_oe_n_o, .sdo_o, .analog_en_o,
  .aux_gpo_oe_n_o, .mixer_current_o, .route_o);
`default_nettype wire
